/* File: rtl/sfupc_mem.sv */
// Byte store of the sample buffer, one write and one registered read port.
// Assumes addresses are kept in range by the pointer logic around it.
`timescale 1ns/1ns
`default_nettype none
`include "sfupc_params.svh"

module sfupc_mem (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [`SFUPC_PTR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [`SFUPC_PTR_W-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] store [0:`SFUPC_DEPTH-1];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
   end

   // The read register refreshes every cycle, so a stale byte lasts one cycle.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= store[rd_addr];
      end
   end
endmodule : sfupc_mem
`default_nettype wire

/* File: rtl/sfupc_packer.sv */
// Turns one captured sample set into a byte stream, one byte per cycle, one empty cycle per disabled word.
// Assumes sample starts are spaced by more than sixteen cycles.
`timescale 1ns/1ns
`default_nettype none
`include "sfupc_params.svh"

module sfupc_packer (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic abort,
   input wire sfupc_pkg::sfupc_sample_t sample,
   input wire logic [`SFUPC_WORDS-1:0] source_enable,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   sfupc_pkg::sfupc_pk_state_t state_r, state_nxt;
   logic [127:0] words_r, words_nxt;
   logic [`SFUPC_WORDS-1:0] mask_r, mask_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic low_r, low_nxt;
   logic [15:0] cur_word;

   // Word 0 sits in the top bits so the fixed order is a plain index walk.
   assign cur_word = words_r[127 - 16*idx_r -: 16];

   always_comb begin
      state_nxt = state_r;
      words_nxt = words_r;
      mask_nxt = mask_r;
      idx_nxt = idx_r;
      low_nxt = low_r;
      byte_valid = 1'b0;
      byte_data = 8'h00;
      case (state_r)
         sfupc_pkg::SFUPC_PK_IDLE: begin
            if (start && !abort) begin
               words_nxt = {sample, `SFUPC_TRAILER_WORD};
               mask_nxt = source_enable;
               idx_nxt = 3'h0;
               low_nxt = 1'b0;
               state_nxt = sfupc_pkg::SFUPC_PK_RUN;
            end
         end
         sfupc_pkg::SFUPC_PK_RUN: begin
            if (abort) begin
               state_nxt = sfupc_pkg::SFUPC_PK_IDLE;
            end else begin
               if (mask_r[`SFUPC_WORDS-1-idx_r]) begin
                  byte_valid = 1'b1;
                  byte_data = low_r ? cur_word[7:0] : cur_word[15:8];
                  low_nxt = !low_r;
               end
               if (!mask_r[`SFUPC_WORDS-1-idx_r] || low_r) begin
                  idx_nxt = 3'(idx_r + 3'h1);
                  if (idx_r == 3'h7) begin
                     state_nxt = sfupc_pkg::SFUPC_PK_IDLE;
                  end
               end
            end
         end
         default: begin
            state_nxt = sfupc_pkg::SFUPC_PK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= sfupc_pkg::SFUPC_PK_IDLE;
         words_r <= 128'h0;
         mask_r <= 8'h00;
         idx_r <= 3'h0;
         low_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         words_r <= words_nxt;
         mask_r <= mask_nxt;
         idx_r <= idx_nxt;
         low_r <= low_nxt;
      end
   end
endmodule : sfupc_packer
`default_nettype wire

/* File: rtl/sfupc_params.svh */
// Offsets, field masks, reset values and sizes of the sensor buffer block.
// Assumes inclusion by bare name from every design file that needs them.
//
// Notes on behaviour
// - Two read-only registers report valid bytes held; capacity is 512 bytes.
// - When full the count reads 512; new samples overwrite the oldest bytes.
// - Each read port access returns the oldest stored byte, first in first out.
// - While capture is enabled, each sample interval pushes the selected data.
// - Every read or write of the port pops and prefetches; host bursts.
// - Enabled words go high byte first, temperature through accel, then trailer.
// - A trailer word left behind is the first data of the next read.
// - After overflow the buffer keeps the most recent 512 bytes, circularly.
// - Reset bits in the user control register clear themselves when done.
// - Capture enable written with flush starts storage at the next sample.
// - Aux enable set means bus master; cleared means primary bus passes through.
// - Flush resets the buffer and clears its contents.
// - Motion engine reset bit resets the engine; host pairs it with enable.
// - Sensor path reset resets analog and digital gyro path functions.
// - Full device reset returns all registers to power-up defaults.
// - Each axis standby bit: one puts the axis in standby, zero runs it.
// - Sleep bit leaves only interface and registers active; clearing restores.
// - Clock field: 0 osc, 1-3 gyro PLL, 4 32k, 5 19.2M, 6 reserved, 7 stop.
// - At power-up the clock source is the internal oscillator.
// - Overflow sets a flag, cleared by status register read or by flush.
`ifndef SFUPC_PARAMS_SVH
`define SFUPC_PARAMS_SVH

`define SFUPC_ADDR_W 8
`define SFUPC_OFS_LEVEL_UPPER 8'h3A
`define SFUPC_OFS_LEVEL_LOWER 8'h3B
`define SFUPC_OFS_READ_PORT 8'h3C
`define SFUPC_OFS_FUNC_CTRL 8'h3D
`define SFUPC_OFS_PWR_CLK 8'h3E

`define SFUPC_RST_FUNC_CTRL 8'h00
`define SFUPC_RST_PWR_CLK 8'h00
`define SFUPC_FUNC_SELFCLR_MASK 8'h0F
`define SFUPC_PWR_SELFCLR_MASK 8'h80

`define SFUPC_DEPTH 512
`define SFUPC_PTR_W 9
`define SFUPC_CNT_W 10
`define SFUPC_CNT_FULL 10'h200
`define SFUPC_WORDS 8
`define SFUPC_TRAILER_WORD 16'h0000

`endif

/* File: rtl/sfupc_pkg.sv */
// Types shared by the sensor buffer block.
// Assumes the params header is compiled alongside.
package sfupc_pkg;

   // -------------------------------------------------------------
   // Register layouts, sample carrier and packer states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      SFUPC_CLK_OSC = 3'h0,
      SFUPC_CLK_PLL_X = 3'h1,
      SFUPC_CLK_PLL_Y = 3'h2,
      SFUPC_CLK_PLL_Z = 3'h3,
      SFUPC_CLK_PLL_32K = 3'h4,
      SFUPC_CLK_PLL_19M = 3'h5,
      SFUPC_CLK_RSVD = 3'h6,
      SFUPC_CLK_STOP = 3'h7
   } sfupc_clk_src_t;

   typedef struct packed {
      logic motion_engine_enable;
      logic capture_enable;
      logic aux_master_enable;
      logic unused4;
      logic aux_reset;
      logic motion_engine_reset;
      logic flush;
      logic sensor_path_reset;
   } sfupc_func_ctrl_t;

   typedef struct packed {
      logic full_reset;
      logic sleep;
      logic axis_x_standby;
      logic axis_y_standby;
      logic axis_z_standby;
      sfupc_clk_src_t clock_source;
   } sfupc_pwr_clk_t;

   typedef struct packed {
      logic [15:0] temp_sample;
      logic [15:0] rate_x_sample;
      logic [15:0] rate_y_sample;
      logic [15:0] rate_z_sample;
      logic [15:0] accel_x_sample;
      logic [15:0] accel_y_sample;
      logic [15:0] accel_z_sample;
   } sfupc_sample_t;

   typedef enum logic [0:0] {
      SFUPC_PK_IDLE = 1'b0,
      SFUPC_PK_RUN = 1'b1
   } sfupc_pk_state_t;

endpackage : sfupc_pkg

/* File: rtl/sfupc_top.sv */
// Sample buffer, user control and power/clock control registers.
// Assumes a serial bus slave outside drives the register strobes, one cycle
// each, on this clock, and that the interrupt status register lives outside.
`timescale 1ns/1ns
`default_nettype none
`include "sfupc_params.svh"

module sfupc_top (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [`SFUPC_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic sample_tick,
   input wire sfupc_pkg::sfupc_sample_t sample,
   input wire logic [`SFUPC_WORDS-1:0] source_enable,
   input wire logic status_read,
   output logic overflow_flag,
   output logic motion_engine_enable,
   output logic motion_engine_reset,
   output logic aux_master_enable,
   output logic pass_through,
   output logic aux_reset,
   output logic sensor_path_reset,
   output logic device_reset,
   output logic sleep_mode,
   output logic axis_x_standby,
   output logic axis_y_standby,
   output logic axis_z_standby,
   output logic [2:0] clock_source,
   output logic clock_stopped
);
   // -------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------
   sfupc_pkg::sfupc_func_ctrl_t func_r, func_nxt;
   sfupc_pkg::sfupc_pwr_clk_t pwr_r, pwr_nxt;
   logic func_hit;
   logic pwr_hit;
   logic hard_rst;

   assign func_hit = reg_wr && (reg_addr == `SFUPC_OFS_FUNC_CTRL);
   assign pwr_hit = reg_wr && (reg_addr == `SFUPC_OFS_PWR_CLK);
   // The full reset bit stands for one cycle and then wipes everything.
   assign hard_rst = pwr_r.full_reset;

   always_comb begin
      // Reset bits live one cycle; each function reset completes in it.
      func_nxt = func_r & ~`SFUPC_FUNC_SELFCLR_MASK;
      pwr_nxt = pwr_r & ~`SFUPC_PWR_SELFCLR_MASK;
      if (func_hit) begin
         func_nxt = reg_wdata;
      end
      if (pwr_hit) begin
         pwr_nxt = reg_wdata;
      end
      if (hard_rst) begin
         func_nxt = `SFUPC_RST_FUNC_CTRL;
         pwr_nxt = `SFUPC_RST_PWR_CLK;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         func_r <= `SFUPC_RST_FUNC_CTRL;
         pwr_r <= `SFUPC_RST_PWR_CLK;
      end else begin
         func_r <= func_nxt;
         pwr_r <= pwr_nxt;
      end
   end

   // -------------------------------------------------------------
   // Function outputs
   // -------------------------------------------------------------
   assign motion_engine_enable = func_r.motion_engine_enable;
   assign motion_engine_reset = func_r.motion_engine_reset | hard_rst;
   assign aux_master_enable = func_r.aux_master_enable;
   assign pass_through = !func_r.aux_master_enable;
   assign aux_reset = func_r.aux_reset | hard_rst;
   assign sensor_path_reset = func_r.sensor_path_reset | hard_rst;
   assign device_reset = hard_rst;
   assign sleep_mode = pwr_r.sleep;
   assign axis_x_standby = pwr_r.axis_x_standby;
   assign axis_y_standby = pwr_r.axis_y_standby;
   assign axis_z_standby = pwr_r.axis_z_standby;
   assign clock_source = pwr_r.clock_source;
   assign clock_stopped = (pwr_r.clock_source == sfupc_pkg::SFUPC_CLK_STOP);

   // -------------------------------------------------------------
   // Sample capture
   // -------------------------------------------------------------
   logic flush;
   logic start;
   logic push;
   logic [7:0] push_data;

   assign flush = func_r.flush | hard_rst;
   // Sleep and a stopped clock both freeze sampling, registers stay live.
   assign start = sample_tick && func_r.capture_enable && !pwr_r.sleep
      && !clock_stopped && !flush;

   sfupc_packer u_packer (
      .clock(clock),
      .reset_n(reset_n),
      .start(start),
      .abort(flush),
      .sample(sample),
      .source_enable(source_enable),
      .byte_valid(push),
      .byte_data(push_data)
   );

   // -------------------------------------------------------------
   // Buffer pointers and level
   // -------------------------------------------------------------
   logic [`SFUPC_PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [`SFUPC_PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [`SFUPC_CNT_W-1:0] count_r, count_nxt;
   logic ovf_r, ovf_nxt;
   logic full;
   logic port_acc;
   logic pop;
   logic push_ok;
   logic [7:0] mem_q;

   assign full = (count_r == `SFUPC_CNT_FULL);
   assign port_acc = (reg_rd || reg_wr) && (reg_addr == `SFUPC_OFS_READ_PORT);
   assign pop = port_acc && (count_r != 10'h000);
   assign push_ok = push && !flush;

   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      ovf_nxt = ovf_r;
      if (status_read) begin
         ovf_nxt = 1'b0;
      end
      if (flush) begin
         wr_ptr_nxt = 9'h000;
         rd_ptr_nxt = 9'h000;
         count_nxt = 10'h000;
         ovf_nxt = 1'b0;
      end else begin
         if (push_ok) begin
            wr_ptr_nxt = 9'(wr_ptr_r + 9'h001);
         end
         // A full buffer drops its oldest byte to make room, keeping the
         // newest 512 bytes; the pop may then point at a half-written word.
         if (pop || (push_ok && full)) begin
            rd_ptr_nxt = 9'(rd_ptr_r + 9'h001);
         end
         if (push_ok && !pop && !full) begin
            count_nxt = 10'(count_r + 10'h001);
         end else if (pop && !push_ok) begin
            count_nxt = 10'(count_r - 10'h001);
         end
         if (push_ok && full && !pop) begin
            ovf_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_r <= 9'h000;
         rd_ptr_r <= 9'h000;
         count_r <= 10'h000;
         ovf_r <= 1'b0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   assign overflow_flag = ovf_r;

   // Reading at the next head keeps the oldest byte prefetched, so a burst
   // sees one byte per access with no wait; a trailer left behind is first.
   sfupc_mem u_mem (
      .clock(clock),
      .reset_n(reset_n),
      .wr_en(push_ok),
      .wr_addr(wr_ptr_r),
      .wr_data(push_data),
      .rd_addr(rd_ptr_nxt),
      .rd_data(mem_q)
   );

   // -------------------------------------------------------------
   // Register read answers
   // -------------------------------------------------------------
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;

   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = reg_rd;
      if (reg_rd) begin
         case (reg_addr)
            `SFUPC_OFS_LEVEL_UPPER: begin
               rdata_nxt = {6'h00, count_r[9:8]};
            end
            `SFUPC_OFS_LEVEL_LOWER: begin
               rdata_nxt = count_r[7:0];
            end
            `SFUPC_OFS_READ_PORT: begin
               rdata_nxt = (count_r != 10'h000) ? mem_q : 8'h00;
            end
            `SFUPC_OFS_FUNC_CTRL: begin
               rdata_nxt = func_r;
            end
            `SFUPC_OFS_PWR_CLK: begin
               rdata_nxt = pwr_r;
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
endmodule : sfupc_top
`default_nettype wire

/* File: testbench/sfupc_checker.sv */
// Port-level assertions for the sensor buffer top module.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module sfupc_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic status_read,
   input wire logic overflow_flag,
   input wire logic motion_engine_reset,
   input wire logic aux_reset,
   input wire logic aux_master_enable,
   input wire logic pass_through,
   input wire logic sensor_path_reset,
   input wire logic device_reset,
   input wire logic sleep_mode,
   input wire logic [2:0] clock_source,
   input wire logic clock_stopped
);
   logic [7:0] wd_r;
   logic fc_w;
   logic pc_w;

   assign fc_w = reg_wr && reg_addr == 8'h3D;
   assign pc_w = reg_wr && reg_addr == 8'h3E;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wd_r <= 8'h00;
      end else begin
         wd_r <= reg_wdata;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_pass_thru_inverse: assert property (pass_through == !aux_master_enable)
      else $error("pass through is not the inverse of aux enable");
   a_aux_enable_write: assert property (fc_w |=> aux_master_enable == wd_r[5])
      else $error("aux enable does not follow its write");
   a_power_fields: assert property (pc_w && !reg_wdata[7] |=>
      sleep_mode == wd_r[6] && clock_source == wd_r[2:0])
      else $error("power fields do not follow their write");
   a_clock_stop_code: assert property (clock_stopped == (clock_source == 3'h7))
      else $error("clock stop flag does not match source code");
   a_full_reset_pulse: assert property (pc_w && reg_wdata[7] |=> device_reset ##1
      (!device_reset && !sleep_mode && clock_source == 3'h0))
      else $error("full reset pulse or defaults wrong");
   a_path_reset_pulse: assert property (fc_w && reg_wdata[0] |=>
      sensor_path_reset ##1 !sensor_path_reset)
      else $error("sensor path reset is not a one cycle pulse");
   a_engine_reset_pulse: assert property (fc_w && reg_wdata[2] |=>
      motion_engine_reset ##1 $fell(motion_engine_reset))
      else $error("engine reset is not a one cycle pulse");
   a_aux_reset_pulse: assert property (fc_w && reg_wdata[3] |=>
      aux_reset ##1 !aux_reset)
      else $error("aux reset is not a one cycle pulse");
   a_overflow_holds: assert property (overflow_flag && !status_read && !reg_wr
      && !$past(reg_wr) && !$past(reg_wr, 2) |=> overflow_flag)
      else $error("overflow flag dropped without a clear");
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read strobe got no answer");
   a_count_upper: assert property (reg_rvalid && $past(reg_addr) == 8'h3A
      |-> reg_rdata[7:2] == 6'h00)
      else $error("count upper byte has stray bits");
endmodule : sfupc_checker

bind sfupc_top sfupc_checker i_sfupc_checker (
   .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .status_read(status_read), .overflow_flag(overflow_flag),
   .motion_engine_reset(motion_engine_reset), .aux_reset(aux_reset),
   .aux_master_enable(aux_master_enable),
   .pass_through(pass_through), .sensor_path_reset(sensor_path_reset),
   .device_reset(device_reset), .sleep_mode(sleep_mode), .clock_source(clock_source),
   .clock_stopped(clock_stopped)
);

`default_nettype wire

/* File: testbench/sfupc_host.sv */
// Host processor model driving the register strobes on the falling edge.
// Assumes strobes are taken at each rising edge and reads answer one cycle later.
`timescale 1ns/1ns
`default_nettype none

module sfupc_host (
   input wire logic clock,
   input wire logic reg_rvalid,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // Strobes stay up on return, so back-to-back calls form one burst.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      @(negedge clock);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clock);
      d = reg_rvalid ? reg_rdata : 8'hXX;
   endtask : rd

   // Released lines flip so that a stale value never passes for a live one.
   task automatic idle();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
      @(negedge clock);
   endtask : idle

   task automatic capture_on();
      wr(8'h3D, 8'h42);
      idle();
   endtask : capture_on

   task automatic halt_input();
      wr(8'h3D, 8'h00);
      idle();
   endtask : halt_input

   task automatic engine_on();
      wr(8'h3D, 8'hAC);
      idle();
   endtask : engine_on

   task automatic pass_mode();
      wr(8'h3D, 8'h88);
      idle();
   endtask : pass_mode

   task automatic use_pll();
      wr(8'h3E, 8'h01);
      idle();
   endtask : use_pll
endmodule : sfupc_host

`default_nettype wire

/* File: testbench/sfupc_top_tb.sv */
// Self-checking bench of the sensor buffer top, with a host model on the strobes.
// Assumes the checker binds itself; the sample side is driven here directly.
`timescale 1ns/1ns
`default_nettype none

module sfupc_top_tb;
   logic clock, reset_n, sample_tick, status_read, reg_wr, reg_rd, reg_rvalid;
   logic overflow_flag, motion_engine_enable, aux_master_enable, pass_through;
   logic sleep_mode, axis_x_standby, axis_y_standby, axis_z_standby;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, source_enable, v;
   logic [2:0] clock_source;
   sfupc_pkg::sfupc_sample_t sample;
   logic [7:0] q[$];
   int err_count, num_checks;

   sfupc_top i_sfupc_top (
      .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .sample_tick(sample_tick), .sample(sample), .source_enable(source_enable),
      .status_read(status_read), .overflow_flag(overflow_flag),
      .motion_engine_enable(motion_engine_enable), .motion_engine_reset(),
      .aux_master_enable(aux_master_enable), .pass_through(pass_through), .aux_reset(),
      .sensor_path_reset(), .device_reset(), .sleep_mode(sleep_mode),
      .axis_x_standby(axis_x_standby), .axis_y_standby(axis_y_standby),
      .axis_z_standby(axis_z_standby), .clock_source(clock_source), .clock_stopped()
   );
   sfupc_host i_sfupc_host (
      .clock(clock), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata)
   );

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // Expected stream: enabled words high byte first, temperature through trailer.
   function automatic void push_set(input logic [127:0] w, input logic [7:0] m);
      for (int i = 7; i >= 0; i--) begin
         if (m[i]) begin
            q.push_back(w[i*16+8 +: 8]);
            q.push_back(w[i*16 +: 8]);
         end
      end
      while (q.size() > 512) void'(q.pop_front());
   endfunction : push_set

   task automatic tick(input logic [7:0] m);
      logic [127:0] r;
      r = {$urandom, $urandom, $urandom, $urandom};
      sample = r[111:0];
      source_enable = m;
      sample_tick = 1'b1;
      @(negedge clock);
      sample_tick = 1'b0;
      push_set({sample, 16'h0000}, m);
      repeat (20) @(negedge clock);
   endtask : tick

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_sfupc_host.rd(a, d);
      i_sfupc_host.idle();
      chk({8'h00, d}, {8'h00, e});
   endtask : rdc

   task automatic cnt(input logic [15:0] e);
      logic [7:0] h, l;
      i_sfupc_host.rd(8'h3A, h);
      i_sfupc_host.rd(8'h3B, l);
      i_sfupc_host.idle();
      chk({h, l}, e);
   endtask : cnt

   // The first byte of a burst after overflow is thrown away by the host.
   task automatic drain(input int n, input logic skip);
      logic [7:0] d, e;
      for (int i = 0; i < n; i++) begin
         e = q.pop_front();
         i_sfupc_host.rd(8'h3C, d);
         if (!skip || i > 0) chk({8'h00, d}, {8'h00, e});
      end
      i_sfupc_host.idle();
   endtask : drain

   initial begin
      repeat (100000) @(posedge clock);
      err_count++;
      final_report();
   end

   initial begin
      reset_n = 1'b0;
      sample_tick = 1'b0;
      status_read = 1'b0;
      source_enable = 8'h00;
      sample = '0;
      err_count = 0;
      num_checks = 0;
      void'($urandom(64));
      repeat (6) @(posedge clock);
      @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      i_sfupc_host.wr(8'h3B, 8'hFF);
      i_sfupc_host.idle();
      for (int a = 8'h3A; a < 8'h3F; a++) rdc(8'(a), 8'h00);
      rdc(8'h5A, 8'h00);
      $display("test reset finished");
      for (int c = 0; c < 8; c++) begin
         v = {1'b0, 4'($urandom), 3'(c)};
         i_sfupc_host.wr(8'h3E, v);
         i_sfupc_host.idle();
         chk({9'h000, sleep_mode, axis_x_standby, axis_y_standby, axis_z_standby,
              clock_source}, {8'h00, v});
         rdc(8'h3E, v);
      end
      $display("test power finished");
      i_sfupc_host.engine_on();
      chk({13'h0000, motion_engine_enable, aux_master_enable, pass_through}, 16'h0006);
      rdc(8'h3D, 8'hA0);
      i_sfupc_host.pass_mode();
      chk({15'h0000, pass_through}, 16'h0001);
      i_sfupc_host.wr(8'h3D, 8'h11);
      i_sfupc_host.idle();
      rdc(8'h3D, 8'h10);
      i_sfupc_host.wr(8'h3E, 8'h80);
      i_sfupc_host.idle();
      i_sfupc_host.idle();
      rdc(8'h3D, 8'h00);
      rdc(8'h3E, 8'h00);
      $display("test control finished");
      i_sfupc_host.use_pll();
      i_sfupc_host.capture_on();
      rdc(8'h3D, 8'h40);
      for (int k = 0; k < 6; k++) begin
         v = k == 0 ? 8'h01 : k == 1 ? 8'hFF : {7'($urandom), 1'b1};
         tick(v);
         cnt(16'(q.size()));
         drain(q.size() - 2, 1'b0);
      end
      $display("test stream finished");
      repeat (34) tick(8'hFF);
      cnt(16'h0200);
      chk({15'h0000, overflow_flag}, 16'h0001);
      i_sfupc_host.halt_input();
      drain(512, 1'b1);
      cnt(16'h0000);
      status_read = 1'b1;
      @(negedge clock);
      status_read = 1'b0;
      @(negedge clock);
      chk({15'h0000, overflow_flag}, 16'h0000);
      $display("test overflow finished");
      i_sfupc_host.capture_on();
      repeat (33) tick(8'hFF);
      chk({15'h0000, overflow_flag}, 16'h0001);
      i_sfupc_host.capture_on();
      q.delete();
      cnt(16'h0000);
      chk({15'h0000, overflow_flag}, 16'h0000);
      $display("test flush finished");
      i_sfupc_host.wr(8'h3E, 8'h41);
      i_sfupc_host.idle();
      tick(8'hFF);
      i_sfupc_host.wr(8'h3E, 8'h07);
      i_sfupc_host.idle();
      tick(8'hFF);
      q.delete();
      cnt(16'h0000);
      i_sfupc_host.use_pll();
      tick(8'h81);
      i_sfupc_host.wr(8'h3C, 8'h00);
      i_sfupc_host.idle();
      void'(q.pop_front());
      cnt(16'h0003);
      drain(1, 1'b0);
      $display("test gating finished");
      final_report();
   end
endmodule : sfupc_top_tb

`default_nettype wire
